// [hdl/ivp_top.v]
// Input overvoltage fault, fault action and per-phase undervoltage warning logic
`timescale 1ns/1ps
`default_nettype none
`include "ivp_defs.vh"

// Summary of operation
// [RULE1] Declare overvoltage fault when input rail exceeds programmed threshold; act per action byte.
// [RULE2] Threshold word: five-bit signed exponent 15:11 resetting 11110b, signed mantissa 10:0.
// [RULE3] Overvoltage threshold accepted only from 4 V to 20 V in 0.25 V steps.
// [RULE4] Out-of-range threshold write rejected as invalid data, status flagged, host alerted.
// [RULE5] On restore, thresholds reload as nearest supported value.
// [RULE6] Overvoltage fault sets none-of-above, input word bit, input fault flag, alerts host.
// [RULE7] Bits 7:6: ignore, delayed shutdown after switching cycles, immediate, 11b invalid.
// [RULE8] Bits 5:3: latch off, 1-6 bounded retries, 7 endless retries. Code latches on a new fault past the limit only for immediate shutdown.
// [RULE9] Restart attempts while rail still high count toward the retry limit.
// [RULE10] Bits 2:0 set shutdown clocks 1/3/7 and restart period multiple of ramp time.
// [RULE11] Action byte is one unsigned byte; invalid encodings rejected and flagged.
// [RULE12] Undervoltage warning raised when rail falls to programmed warning level.
// [RULE13] Undervoltage threshold and detection held independently per phase.
// [RULE14] Undervoltage warning sets none-of-above, input word bit, warning flag, alerts host.
// [RULE15] Undervoltage threshold exponent resets 11110b; accepts 2.5 V to 15.5 V.
// [RULE16] Restart period ramp unit equals the programmed soft-start time.
// [RULE17] Attempt counter clears after successful start or command off.
module ivp_top #(
	parameter PHASES = 4,
	parameter VW     = 14,
	parameter RW     = 24
) (
	input  wire                  clk,
	input  wire                  rst_n,
	input  wire                  cmd_valid,
	input  wire                  cmd_write,
	input  wire [7:0]            cmd_code,
	input  wire [15:0]           cmd_wdata,
	input  wire [1:0]            phase_sel,
	output reg                   rsp_valid_q,
	output reg  [15:0]           rsp_rdata_q,
	input  wire                  nvm_restore,
	input  wire                  clear_faults,
	input  wire                  switch_clk,
	input  wire [PHASES*VW-1:0]  rail_meas,
	input  wire                  enable,
	input  wire                  start_done,
	input  wire [RW-1:0]         soft_start_ramp_time,
	output reg                   power_en_q,
	output reg  [7:0]            status_byte_q,
	output reg  [7:0]            status_word_hi_q,
	output reg  [7:0]            status_input_q,
	output reg  [7:0]            status_cml_q,
	output reg  [PHASES-1:0]     input_under_warn_flag_q,
	output reg                   alert_q
);

	// ==========================================================
	// Linear format helpers
	// ==========================================================
	// Value in 1/64 V; -1 for negative, too large or finer than 1/64 V
	function integer lin_val;
		input [15:0] w;
		integer m;
		integer s;
		begin
			m = w[`IVP_MAN_HI:0];
			s = $signed(w[`IVP_EXP_HI:`IVP_EXP_LO]) + `IVP_FRAC_BITS;
			if (w[`IVP_MAN_HI] || s > 18)
				lin_val = -1;
			else if (s >= 0)
				lin_val = m << s;
			else if (((m >> (-s)) << (-s)) != m)
				lin_val = -1;
			else
				lin_val = m >> (-s);
		end
	endfunction

	// Quarter-volt count, rounded to nearest and clamped to the supported span
	function [15:0] nearest;
		input [15:0] w;
		input integer lo;
		input integer hi;
		integer m;
		integer s;
		integer q;
		begin
			m = w[`IVP_MAN_HI:0];
			s = $signed(w[`IVP_EXP_HI:`IVP_EXP_LO]) + `IVP_FRAC_BITS;
			if (w[`IVP_MAN_HI])
				q = lo;
			else if (s > 18)
				q = hi;
			else if (s >= 0)
				q = ((m << s) + 8) >> `IVP_Q_SHIFT;
			else
				q = (((m << 12) >> (-s)) + 32768) >> 16;
			if (q < lo)
				q = lo;
			if (q > hi)
				q = hi;
			nearest = {`IVP_EXP_RESET, q[10:0]};
		end
	endfunction

	function range_ok;
		input [15:0] w;
		input integer lo;
		input integer hi;
		integer v;
		begin
			v = lin_val(w);
			range_ok = (v >= (lo << `IVP_Q_SHIFT)) && (v <= (hi << `IVP_Q_SHIFT)) &&
			           (v[3:0] == 4'h0);
		end
	endfunction

	// ==========================================================
	// Switching clock edge finder
	// ==========================================================
	reg  [2:0] sw_sync_q;
	wire       sw_rise = sw_sync_q[1] & ~sw_sync_q[2];
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sw_sync_q <= 3'h0;
		else
			sw_sync_q <= {sw_sync_q[1:0], switch_clk};
	end

	// ==========================================================
	// Command registers
	// ==========================================================
	reg  [15:0] ov_thr_q;
	reg  [7:0]  ov_act_q;
	reg  [15:0] uv_thr_q [0:PHASES-1];
	wire        wr       = cmd_valid & cmd_write;
	wire        wr_ov    = wr && cmd_code == `IVP_CMD_OV_THR;
	wire        wr_act   = wr && cmd_code == `IVP_CMD_OV_ACT;
	wire        wr_uv    = wr && cmd_code == `IVP_CMD_UV_THR;
	wire        ov_ok    = range_ok(cmd_wdata, `IVP_OV_MIN_Q, `IVP_OV_MAX_Q); // [RULE3]
	wire        uv_ok    = range_ok(cmd_wdata, `IVP_UV_MIN_Q, `IVP_UV_MAX_Q); // [RULE15]
	wire        act_ok   = cmd_wdata[`IVP_ACT_SEL_HI:`IVP_ACT_SEL_LO] != 2'h3; // [RULE11]
	wire        bad_data = (wr_ov & ~ov_ok) | (wr_act & ~act_ok) | (wr_uv & ~uv_ok); // [RULE4]
	wire        bad_cmd  = cmd_valid & ~(cmd_code == `IVP_CMD_OV_THR ||
	                       cmd_code == `IVP_CMD_OV_ACT || cmd_code == `IVP_CMD_UV_THR);
	integer i;
	integer j;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ov_thr_q <= `IVP_OV_THR_RESET; // [RULE2]
			ov_act_q <= `IVP_ACT_RESET;
			for (i = 0; i < PHASES; i = i + 1)
				uv_thr_q[i] <= `IVP_UV_THR_RESET; // [RULE15]
		end else if (nvm_restore) begin
			ov_thr_q <= nearest(ov_thr_q, `IVP_OV_MIN_Q, `IVP_OV_MAX_Q); // [RULE5]
			for (i = 0; i < PHASES; i = i + 1)
				uv_thr_q[i] <= nearest(uv_thr_q[i], `IVP_UV_MIN_Q, `IVP_UV_MAX_Q);
		end else begin
			if (wr_ov && ov_ok)
				ov_thr_q <= cmd_wdata;
			if (wr_act && act_ok)
				ov_act_q <= cmd_wdata[7:0]; // [RULE11]
			if (wr_uv && uv_ok)
				uv_thr_q[phase_sel] <= cmd_wdata; // [RULE13]
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid_q <= 1'b0;
			rsp_rdata_q <= 16'h0000;
		end else begin
			rsp_valid_q <= cmd_valid & ~cmd_write;
			case (cmd_code)
			`IVP_CMD_OV_THR: rsp_rdata_q <= ov_thr_q;
			`IVP_CMD_OV_ACT: rsp_rdata_q <= {8'h00, ov_act_q};
			`IVP_CMD_UV_THR: rsp_rdata_q <= uv_thr_q[phase_sel];
			default:         rsp_rdata_q <= 16'h0000;
			endcase
		end
	end

	// ==========================================================
	// Detection
	// ==========================================================
	// Phase 0 carries the rail for the overvoltage comparator
	wire             ov_now = $signed({1'b0, rail_meas[VW-1:0]}) > lin_val(ov_thr_q); // [RULE1]
	reg [PHASES-1:0] uv_now;
	always @* begin
		for (j = 0; j < PHASES; j = j + 1)
			uv_now[j] = $signed({1'b0, rail_meas[j*VW +: VW]}) <= lin_val(uv_thr_q[j]); // [RULE12]
	end

	// ==========================================================
	// Fault action sequencer
	// ==========================================================
	localparam ST_RUN   = 3'h0;
	localparam ST_DELAY = 3'h1;
	localparam ST_WAIT  = 3'h2;
	localparam ST_LATCH = 3'h3;
	localparam ST_OFF   = 3'h4;
	wire [1:0] sel    = ov_act_q[`IVP_ACT_SEL_HI:`IVP_ACT_SEL_LO];
	wire [2:0] policy = ov_act_q[`IVP_POL_HI:`IVP_POL_LO];
	wire [2:0] dsel   = ov_act_q[`IVP_DLY_HI:`IVP_DLY_LO];
	wire [2:0] dclk   = (dsel < 3'h2) ? `IVP_DLY_SHORT :
	                    (dsel < 3'h5) ? `IVP_DLY_MID : `IVP_DLY_LONG; // [RULE10]
	wire [2:0] mult   = (dsel == 3'h0) ? 3'h1 : dsel;
	reg  [2:0]      st_q;
	reg  [2:0]      dcnt_q;
	reg  [2:0]      tries_q;
	reg  [2:0]      mcnt_q;
	reg  [RW-1:0]   rcnt_q;
	wire retry_end = (policy == `IVP_POL_LATCH) ||
	                 (policy != `IVP_POL_ENDLESS && tries_q >= policy); // [RULE8]
	wire ramp_end  = rcnt_q >= soft_start_ramp_time - 1'b1; // [RULE16]

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= ST_OFF;
			dcnt_q     <= 3'h0;
			tries_q    <= 3'h0;
			mcnt_q     <= 3'h0;
			rcnt_q     <= {RW{1'b0}};
			power_en_q <= 1'b0;
		end else if (!enable) begin
			st_q       <= ST_OFF;
			tries_q    <= 3'h0; // [RULE17]
			power_en_q <= 1'b0;
		end else begin
			case (st_q)
			ST_OFF: begin
				st_q       <= ST_RUN;
				power_en_q <= 1'b1;
			end
			ST_RUN: begin
				if (start_done)
					tries_q <= 3'h0; // [RULE17]
				dcnt_q <= 3'h0;
				if (ov_now && sel == `IVP_SEL_DELAYED) begin
					st_q <= ST_DELAY; // [RULE7]
				end else if (ov_now && sel == `IVP_SEL_IMMEDIATE) begin
					power_en_q <= 1'b0;
					st_q       <= (policy == `IVP_POL_LATCH) ? ST_LATCH : ST_WAIT;
				end
				mcnt_q <= 3'h0;
				rcnt_q <= {RW{1'b0}};
			end
			ST_DELAY: begin
				if (!ov_now) begin
					st_q <= ST_RUN;
				end else if (sw_rise) begin
					dcnt_q <= dcnt_q + 3'h1;
					if (dcnt_q + 3'h1 >= dclk) begin // [RULE10]
						power_en_q <= 1'b0;
						st_q       <= (policy == `IVP_POL_LATCH) ? ST_LATCH : ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				rcnt_q <= ramp_end ? {RW{1'b0}} : rcnt_q + 1'b1;
				if (ramp_end) begin
					mcnt_q <= mcnt_q + 3'h1;
					if (mcnt_q + 3'h1 >= mult) begin
						mcnt_q <= 3'h0;
						if (policy != `IVP_POL_ENDLESS)
							tries_q <= tries_q + 3'h1;
						if (ov_now) begin
							// Unseen attempt still spends one try
							if (policy != `IVP_POL_ENDLESS && tries_q + 3'h1 >= policy)
								st_q <= ST_LATCH; // [RULE9]
						end else begin
							st_q       <= ST_RUN;
							power_en_q <= 1'b1;
						end
					end
				end
			end
			ST_LATCH: power_en_q <= 1'b0;
			default:  st_q <= ST_OFF;
			endcase
			if (st_q == ST_RUN && ov_now && sel != `IVP_SEL_IGNORE && retry_end &&
			    policy != `IVP_POL_LATCH && sel == `IVP_SEL_IMMEDIATE)
				st_q <= ST_LATCH;
		end
	end

	// ==========================================================
	// Status and alert
	// ==========================================================
	// Sticky bits; a fresh event in the clear cycle wins
	wire ev_ov = ov_now;
	wire ev_uv = |uv_now;
	wire ev_in = ev_ov | ev_uv;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_byte_q           <= 8'h00;
			status_word_hi_q        <= 8'h00;
			status_input_q          <= 8'h00;
			status_cml_q            <= 8'h00;
			input_under_warn_flag_q <= {PHASES{1'b0}};
			alert_q                 <= 1'b0;
		end else begin
			status_input_q[`IVP_SI_OV_FAULT] <= ev_ov |
			    (status_input_q[`IVP_SI_OV_FAULT] & ~clear_faults); // [RULE6]
			status_input_q[`IVP_SI_UV_WARN]  <= ev_uv |
			    (status_input_q[`IVP_SI_UV_WARN] & ~clear_faults); // [RULE14]
			input_under_warn_flag_q <= uv_now |
			    (input_under_warn_flag_q & {PHASES{~clear_faults}}); // [RULE13]
			status_word_hi_q[`IVP_SWH_INPUT] <= ev_in |
			    (status_word_hi_q[`IVP_SWH_INPUT] & ~clear_faults);
			status_byte_q[`IVP_SB_NONE_ABOVE] <= ev_in |
			    (status_byte_q[`IVP_SB_NONE_ABOVE] & ~clear_faults);
			status_cml_q[`IVP_CML_BAD_DATA] <= bad_data |
			    (status_cml_q[`IVP_CML_BAD_DATA] & ~clear_faults); // [RULE4]
			status_cml_q[`IVP_CML_BAD_CMD]  <= bad_cmd |
			    (status_cml_q[`IVP_CML_BAD_CMD] & ~clear_faults);
			status_byte_q[`IVP_SB_CML] <= bad_data | bad_cmd |
			    (status_byte_q[`IVP_SB_CML] & ~clear_faults);
			alert_q <= ev_in | bad_data | bad_cmd | (alert_q & ~clear_faults);
		end
	end

endmodule
`default_nettype wire

// [hdl/ivp_defs.vh]
// Command codes, field positions, reset values and limits of the input protection commands
`ifndef IVP_DEFS_VH
`define IVP_DEFS_VH
`define IVP_CMD_OV_THR        8'h55
`define IVP_CMD_OV_ACT        8'h56
`define IVP_CMD_UV_THR        8'h58
`define IVP_EXP_HI            15
`define IVP_EXP_LO            11
`define IVP_MAN_HI            10
`define IVP_EXP_RESET         5'h1E
`define IVP_OV_THR_RESET      16'hF050
`define IVP_UV_THR_RESET      16'hF020
`define IVP_ACT_RESET         8'h00
`define IVP_ACT_SEL_HI        7
`define IVP_ACT_SEL_LO        6
`define IVP_POL_HI            5
`define IVP_POL_LO            3
`define IVP_DLY_HI            2
`define IVP_DLY_LO            0
`define IVP_SEL_IGNORE        2'h0
`define IVP_SEL_DELAYED       2'h1
`define IVP_SEL_IMMEDIATE     2'h2
`define IVP_POL_LATCH         3'h0
`define IVP_POL_ENDLESS       3'h7
`define IVP_OV_MIN_Q          32'h00000010
`define IVP_OV_MAX_Q          32'h00000050
`define IVP_UV_MIN_Q          32'h0000000A
`define IVP_UV_MAX_Q          32'h0000003E
`define IVP_FRAC_BITS         6
`define IVP_Q_SHIFT           4
`define IVP_DLY_SHORT         3'h1
`define IVP_DLY_MID           3'h3
`define IVP_DLY_LONG          3'h7
`define IVP_SB_NONE_ABOVE     0
`define IVP_SB_CML            1
`define IVP_SWH_INPUT         5
`define IVP_SI_OV_FAULT       7
`define IVP_SI_UV_WARN        5
`define IVP_CML_BAD_CMD       7
`define IVP_CML_BAD_DATA      6
`endif

// [verification/ivp_properties.sv]
// Concurrent checks on the ports of the input protection block
`timescale 1ns/1ps
`default_nettype none
module ivp_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        cmd_valid,
	input wire logic        cmd_write,
	input wire logic [7:0]  cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic        enable,
	input wire logic        clear_faults,
	input wire logic        rsp_valid_q,
	input wire logic        power_en_q,
	input wire logic        alert_q,
	input wire logic [7:0]  status_byte_q,
	input wire logic [7:0]  status_word_hi_q,
	input wire logic [7:0]  status_input_q,
	input wire logic [7:0]  status_cml_q
);
	// ==========
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence rd_req; cmd_valid && !cmd_write; endsequence
	sequence wr_act; cmd_valid && cmd_write && cmd_code == 8'h56; endsequence
	sequence wr_ovt; cmd_valid && cmd_write && cmd_code == 8'h55; endsequence
	sequence flagged; ##[1:2] (status_cml_q[6] && alert_q); endsequence
	rd_answer_a: assert property (rd_req |=> rsp_valid_q)
		else $error("read not answered");
	resp_cause_a: assert property (rsp_valid_q |-> $past(cmd_valid && !cmd_write))
		else $error("answer without read");
	bad_action_a: assert property (wr_act ##0 cmd_wdata[7:6] == 2'h3 |-> flagged)
		else $error("invalid action byte not flagged");
	bad_limit_a: assert property (
		wr_ovt ##0 (cmd_wdata[15:11] == 5'h1E && cmd_wdata[10:0] > 11'h050) |-> flagged)
		else $error("out of range limit not flagged");
	ov_status_a: assert property ($rose(status_input_q[7]) |->
		##[0:1] (status_byte_q[0] && status_word_hi_q[5] && alert_q))
		else $error("overvoltage status incomplete");
	uv_status_a: assert property ($rose(status_input_q[5]) |->
		##[0:1] (status_byte_q[0] && status_word_hi_q[5] && alert_q))
		else $error("undervoltage status incomplete");
	alert_sticky_a: assert property ($fell(alert_q) |->
		$past(clear_faults) || $past(clear_faults, 2))
		else $error("alert dropped without clear");
	off_disabled_a: assert property (!enable [*2] |=> !power_en_q)
		else $error("power stage on while disabled");
endmodule
bind ivp_top ivp_checker chk_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
	.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .enable(enable),
	.clear_faults(clear_faults), .rsp_valid_q(rsp_valid_q), .power_en_q(power_en_q),
	.alert_q(alert_q), .status_byte_q(status_byte_q), .status_word_hi_q(status_word_hi_q),
	.status_input_q(status_input_q), .status_cml_q(status_cml_q));
`default_nettype wire

// [verification/ivp_host.sv]
// Host model driving the command port of the protection block
`timescale 1ns/1ps
`default_nettype none
module ivp_host (
	input  wire logic        clk,
	output logic             cmd_valid = 1'b0,
	output logic             cmd_write = 1'b0,
	output logic [7:0]       cmd_code  = 8'h00,
	output logic [15:0]      cmd_wdata = 16'h0000,
	output logic [1:0]       phase_sel = 2'h0,
	input  wire logic [15:0] rsp_rdata_q
);
	// ==========
	// One command per call, words sent whole, byte data in the low byte
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		input logic [1:0] p, output logic [15:0] r);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_write = w;
		cmd_code = c;
		cmd_wdata = d;
		phase_sel = p;
		@(negedge clk);
		// Read data follows the code lines, so take it before they move
		r = rsp_rdata_q;
		cmd_valid = 1'b0;
		// Released lines show garbage so stale data cannot pass
		cmd_code = ~c;
		cmd_wdata = ~d;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// [verification/ivp_top_tb.sv]
// Self-checking bench for the input protection command block
`timescale 1ns/1ps
`default_nettype none
module ivp_top_tb;
	logic        clk = 0, rst_n = 0, nvm_restore = 0, clear_faults = 0;
	logic        switch_clk = 0, enable = 1, start_done = 0;
	logic        cmd_valid, cmd_write, rsp_valid_q, power_en_q, alert_q;
	logic [7:0]  cmd_code, status_byte_q, status_word_hi_q, status_input_q, status_cml_q;
	logic [15:0] cmd_wdata, rsp_rdata_q, r;
	logic [1:0]  phase_sel;
	logic [3:0]  input_under_warn_flag_q;
	logic [55:0] rail_meas = {4{14'h0300}};
	logic [23:0] soft_start_ramp_time = 24'h000004;
	int          fails = 0, tests_run = 0, cyc = 0;
	ivp_top  dut (.*);
	ivp_host host (.*);
	always #5 clk = ~clk;
	always #80 switch_clk = ~switch_clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			print_verdict;
		end
	end
	// ==========
	// Access and check tasks
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(logic [7:0] c, logic [15:0] d, logic [1:0] p = 0);
		host.xfer(1'b1, c, d, p, r);
	endtask
	task automatic rd(string n, logic [7:0] c, logic [15:0] e, logic [1:0] p = 0);
		host.xfer(1'b0, c, 16'h0000, p, r);
		chk(n, e, r);
	endtask
	task automatic cy(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic ovr(logic [13:0] v);
		cy(1);
		rail_meas[13:0] = v;
	endtask
	task automatic pw(logic e, int n);
		for (int i = 0; i < n && power_en_q !== e; i++) cy(1);
		chk("power", e, power_en_q);
	endtask
	task automatic clr;
		cy(1);
		clear_faults = 1;
		cy(1);
		clear_faults = 0;
		cy(2);
	endtask
	task automatic restart;
		ovr(14'h0300);
		enable = 0;
		cy(3);
		enable = 1;
		pw(1, 10);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// ==========
	// Tests
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk) rst_n = 1;
		rd("ov_thr", 8'h55, 16'hF050);
		rd("uv_thr", 8'h58, 16'hF020);
		rd("ov_act", 8'h56, 16'h0000);
		$display("test reset done");
		wr(8'h55, 16'hF054);
		rd("ov_thr", 8'h55, 16'hF050);
		chk("cml", 16'h0040, status_cml_q);
		wr(8'h55, 16'hF00F);
		wr(8'h55, 16'hF010);
		rd("ov_thr", 8'h55, 16'hF010);
		wr(8'h55, 16'hF041);
		rd("ov_thr", 8'h55, 16'hF041);
		wr(8'h56, 16'h00C0);
		rd("ov_act", 8'h56, 16'h0000);
		wr(8'h57, 16'h0000);
		chk("cml", 16'h00C0, status_cml_q);
		clr;
		chk("alert", 0, alert_q);
		$display("test limits done");
		ovr(14'h0440);
		cy(30);
		chk("power", 1, power_en_q);
		chk("st_in", 16'h0080, status_input_q);
		chk("st_byte", 16'h0001, status_byte_q);
		chk("st_word", 16'h0020, status_word_hi_q);
		chk("alert", 1, alert_q);
		ovr(14'h0300);
		clr;
		wr(8'h56, 16'h0080);
		rd("ov_act", 8'h56, 16'h0080);
		ovr(14'h0440);
		pw(0, 4);
		ovr(14'h0300);
		cy(60);
		chk("power", 0, power_en_q);
		restart;
		$display("test shutdown done");
		// Seven switching clocks take at least 96 cycles here
		wr(8'h56, 16'h0045);
		ovr(14'h0440);
		cy(90);
		chk("power", 1, power_en_q);
		pw(0, 40);
		restart;
		wr(8'h56, 16'h0092);
		ovr(14'h0440);
		cy(100);
		ovr(14'h0300);
		cy(60);
		chk("power", 0, power_en_q);
		restart;
		wr(8'h56, 16'h00BA);
		ovr(14'h0440);
		cy(100);
		chk("power", 0, power_en_q);
		ovr(14'h0300);
		pw(1, 40);
		$display("test retry done");
		wr(8'h58, 16'hF028, 2'h1);
		rd("uv_thr1", 8'h58, 16'hF028, 2'h1);
		rd("uv_thr0", 8'h58, 16'hF020);
		wr(8'h58, 16'hF03F, 2'h2);
		rd("uv_thr2", 8'h58, 16'hF020, 2'h2);
		clr;
		rail_meas[27:14] = 14'h0240;
		cy(5);
		chk("uv_flag", 16'h0002, input_under_warn_flag_q);
		chk("st_in", 16'h0020, status_input_q);
		chk("st_byte", 16'h0001, status_byte_q);
		chk("alert", 1, alert_q);
		$display("test undervoltage done");
		nvm_restore = 1;
		cy(1);
		nvm_restore = 0;
		rd("ov_restore", 8'h55, 16'hF041);
		rd("uv_restore", 8'h58, 16'hF028, 2'h1);
		$display("test restore done");
		print_verdict;
	end
endmodule
`default_nettype wire
